// ### include/cwc_pkg.sv
// Constants and helpers for the read-before-write comparison registers.
// Assumes a byte-wide control bus with 5-bit register addresses.
package cwc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_SRC = 3;
  // Source register slots
  localparam int SRC_IRQ = 0;
  localparam int SRC_TXS = 1;
  localparam int SRC_RXA = 2;
  // Comparison registers
  localparam logic [4:0] IRQ_COND_SNAPSHOT_ADDR = 5'h1a;
  localparam logic [4:0] TX_STATE_SNAPSHOT_ADDR = 5'h1b;
  localparam logic [4:0] RX_COND_A_SNAPSHOT_ADDR = 5'h1c;
  // Source registers, held elsewhere in the device
  localparam logic [4:0] INTERRUPT_CONDITION_ADDR = 5'h07;
  localparam logic [4:0] TRANSMIT_STATE_ADDR = 5'h03;
  localparam logic [4:0] RX_CONDITION_A_ADDR = 5'h0a;
  localparam logic [7:0] SNAP_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // Interrupt condition layout
  localparam int REQ_DATA_PARITY_ERR_BIT = 0;
  localparam int CTRL_BUS_PARITY_ERR_BIT = 1;
  localparam int WRITE_REJECT_FLAG_BIT = 2;
  localparam int WRITE_INHIBIT_FLAG_BIT = 3;
  localparam int LINK_ERROR_THRESHOLD_FLAG_BIT = 4;
  localparam int RX_COND_A_FLAG_BIT = 5;
  localparam int RX_COND_B_FLAG_BIT = 6;
  localparam int USER_EVENT_FLAG_BIT = 7;
  localparam logic [7:0] WRITE_INHIBIT_MASK = 8'h08;
  // Transmit state layout
  localparam int TRANSMIT_MODE_LSB = 0;
  localparam int TRANSMIT_MODE_MSB = 2;
  localparam int INJECTION_CONTROL_LSB = 3;
  localparam int INJECTION_CONTROL_MSB = 4;
  localparam int SMOOTHER_ENABLE_BIT = 5;
  localparam int REQ_PARITY_CHECK_ENABLE_BIT = 6;
  // Receive condition A layout
  localparam int NO_SIGNAL_FLAG_BIT = 0;
  localparam int QUIET_LINE_FLAG_BIT = 1;
  localparam int HALT_LINE_FLAG_BIT = 2;
  localparam int MASTER_LINE_FLAG_BIT = 3;
  localparam int NOISE_LINE_FLAG_BIT = 4;
  localparam int NOISE_THRESHOLD_FLAG_BIT = 5;
  localparam int LINE_STATE_CHANGE_FLAG_BIT = 6;
  localparam int UNKNOWN_LINE_PHY_INVALID_BIT = 7;

  function automatic logic [4:0] src_addr(input int idx);
    case (idx)
      SRC_IRQ: src_addr = INTERRUPT_CONDITION_ADDR;
      SRC_TXS: src_addr = TRANSMIT_STATE_ADDR;
      default: src_addr = RX_CONDITION_A_ADDR;
    endcase
  endfunction

  function automatic logic [4:0] snap_addr(input int idx);
    case (idx)
      SRC_IRQ: snap_addr = IRQ_COND_SNAPSHOT_ADDR;
      SRC_TXS: snap_addr = TX_STATE_SNAPSHOT_ADDR;
      default: snap_addr = RX_COND_A_SNAPSHOT_ADDR;
    endcase
  endfunction

  // Bits that moved since the last snapshot and must be kept
  function automatic logic [7:0] keep_mask(input logic [7:0] cur, input logic [7:0] snap);
    keep_mask = cur ^ snap;
  endfunction

  function automatic logic [7:0] merge_bits(input logic [7:0] cur, input logic [7:0] snap,
                                            input logic [7:0] wdata);
    merge_bits = (wdata & ~keep_mask(cur, snap)) | (cur & keep_mask(cur, snap));
  endfunction
endpackage

// ### include/cwc_port_if.sv
// Carrier between the bus decode and one comparison unit.
// Assumes one unit per guarded source register.
`timescale 1ns/1ps
interface cwc_port_if;
  logic rd_hit;
  logic snap_wr;
  logic [7:0] wdata;
  logic [7:0] cur;
  logic [7:0] snap;
  logic [7:0] merged;
  logic inhibit;

  modport ctrl (
    output rd_hit,
    output snap_wr,
    output wdata,
    output cur,
    input snap,
    input merged,
    input inhibit
  );
  modport unit (
    input rd_hit,
    input snap_wr,
    input wdata,
    input cur,
    output snap,
    output merged,
    output inhibit
  );
endinterface

// ### src/cwc_unit.sv
// One comparison register and its per-bit conditional write merge.
// Assumes hit strobes are single-cycle and already qualified by address.
`timescale 1ns/1ps
module cwc_unit (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  cwc_port_if.unit p
);
  logic [7:0] snap_reg;
  logic [7:0] snap_next;

  // A source read overrides a direct write so the snapshot always tracks the read
  assign snap_next = p.rd_hit ? p.cur : (p.snap_wr ? p.wdata : snap_reg);

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      snap_reg <= cwc_pkg::SNAP_RESET;
    end
    else
    begin
      snap_reg <= snap_next;
    end
  end

  assign p.snap = snap_reg;
  // Each bit position is judged on its own
  assign p.merged = cwc_pkg::merge_bits(p.cur, snap_reg, p.wdata);
  assign p.inhibit = |cwc_pkg::keep_mask(p.cur, snap_reg);
endmodule

// ### src/cond_write_compare_regs.sv
// Read-before-write guard for three device-modified registers.
// Assumes the source registers live elsewhere and take the write pulses
// and merged data driven here; read and write strobes never coincide.
`timescale 1ns/1ps
module cond_write_compare_regs (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_cb_rd,
  input wire logic i_cb_wr,
  input wire logic [4:0] i_cb_addr,
  input wire logic [7:0] i_cb_wdata,
  input wire logic [7:0] i_interrupt_condition_reg,
  input wire logic [7:0] i_transmit_state_reg,
  input wire logic [7:0] i_rx_condition_a_reg,
  output logic [7:0] o_cb_rdata,
  output logic o_irq_wr_en,
  output logic [7:0] o_irq_wr_data,
  output logic o_txs_wr_en,
  output logic [7:0] o_txs_wr_data,
  output logic o_rxa_wr_en,
  output logic [7:0] o_rxa_wr_data,
  output logic o_write_inhibit_set
);
  cwc_port_if port_if[cwc_pkg::NUM_SRC] ();

  logic [7:0] cur_val [cwc_pkg::NUM_SRC];
  logic [2:0] src_wr;
  logic [2:0] src_rd;
  logic [2:0] snap_rd;
  logic [2:0] inhibit_hit;
  logic any_inhibit;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic [2:0] wr_en_reg;
  logic [7:0] wr_data_reg [cwc_pkg::NUM_SRC];
  logic [7:0] wr_data_next [cwc_pkg::NUM_SRC];
  logic inhibit_reg;

  assign cur_val[cwc_pkg::SRC_IRQ] = i_interrupt_condition_reg;
  assign cur_val[cwc_pkg::SRC_TXS] = i_transmit_state_reg;
  assign cur_val[cwc_pkg::SRC_RXA] = i_rx_condition_a_reg;

  genvar g;
  generate
    for (g = 0; g < cwc_pkg::NUM_SRC; g++)
    begin : gen_src
      assign src_rd[g] = i_cb_rd && (i_cb_addr == cwc_pkg::src_addr(g));
      assign src_wr[g] = i_cb_wr && (i_cb_addr == cwc_pkg::src_addr(g));
      assign snap_rd[g] = i_cb_rd && (i_cb_addr == cwc_pkg::snap_addr(g));
      // Snapshot taken on every read of the source
      assign port_if[g].rd_hit = src_rd[g];
      assign port_if[g].snap_wr = i_cb_wr && (i_cb_addr == cwc_pkg::snap_addr(g));
      assign port_if[g].wdata = i_cb_wdata;
      assign port_if[g].cur = cur_val[g];
      // Inhibit only when some bit differs from the snapshot, taken at the last source read or snapshot write
      assign inhibit_hit[g] = src_wr[g] && port_if[g].inhibit;
      cwc_unit u_unit (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .p(port_if[g])
      );
    end
  endgenerate

  assign any_inhibit = |inhibit_hit;

  // Moved bits keep their value, the rest take the write
  assign wr_data_next[cwc_pkg::SRC_TXS] = port_if[cwc_pkg::SRC_TXS].merged;
  assign wr_data_next[cwc_pkg::SRC_RXA] = port_if[cwc_pkg::SRC_RXA].merged;
  // Inhibit set wins over a clear written into the same interrupt register
  assign wr_data_next[cwc_pkg::SRC_IRQ] = port_if[cwc_pkg::SRC_IRQ].merged
    | (any_inhibit ? cwc_pkg::WRITE_INHIBIT_MASK : 8'h00);

  // Reads of sources echo live contents so one port serves the whole map
  assign rdata_next =
    snap_rd[cwc_pkg::SRC_IRQ] ? port_if[cwc_pkg::SRC_IRQ].snap :
    snap_rd[cwc_pkg::SRC_TXS] ? port_if[cwc_pkg::SRC_TXS].snap :
    snap_rd[cwc_pkg::SRC_RXA] ? port_if[cwc_pkg::SRC_RXA].snap :
    src_rd[cwc_pkg::SRC_IRQ] ? i_interrupt_condition_reg :
    src_rd[cwc_pkg::SRC_TXS] ? i_transmit_state_reg :
    src_rd[cwc_pkg::SRC_RXA] ? i_rx_condition_a_reg :
    cwc_pkg::READ_NONE;

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata_reg <= cwc_pkg::READ_NONE;
    end
    else if (i_cb_rd)
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_en_reg <= 3'h0;
      inhibit_reg <= 1'b0;
    end
    else
    begin
      wr_en_reg <= src_wr;
      inhibit_reg <= any_inhibit;
    end
  end

  generate
    for (g = 0; g < cwc_pkg::NUM_SRC; g++)
    begin : gen_out
      always_ff @(posedge i_sys_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          wr_data_reg[g] <= cwc_pkg::SNAP_RESET;
        end
        else
        begin
          wr_data_reg[g] <= wr_data_next[g];
        end
      end
    end
  endgenerate

  assign o_cb_rdata = rdata_reg;
  assign o_irq_wr_en = wr_en_reg[cwc_pkg::SRC_IRQ];
  assign o_txs_wr_en = wr_en_reg[cwc_pkg::SRC_TXS];
  assign o_rxa_wr_en = wr_en_reg[cwc_pkg::SRC_RXA];
  assign o_irq_wr_data = wr_data_reg[cwc_pkg::SRC_IRQ];
  assign o_txs_wr_data = wr_data_reg[cwc_pkg::SRC_TXS];
  assign o_rxa_wr_data = wr_data_reg[cwc_pkg::SRC_RXA];
  assign o_write_inhibit_set = inhibit_reg;

  // Checks
  default clocking cb_chk @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic [7:0] irq_snap;
  logic [7:0] txs_snap;
  logic [7:0] rxa_snap;
  assign irq_snap = port_if[cwc_pkg::SRC_IRQ].snap;
  assign txs_snap = port_if[cwc_pkg::SRC_TXS].snap;
  assign rxa_snap = port_if[cwc_pkg::SRC_RXA].snap;

  sequence s_read(logic [4:0] a);
    i_cb_rd && !i_cb_wr && (i_cb_addr == a);
  endsequence

  sequence s_write(logic [4:0] a);
    i_cb_wr && !i_cb_rd && (i_cb_addr == a);
  endsequence

  property p_readback(logic [4:0] src_a, logic [4:0] cmp_a, logic [7:0] src_v);
    logic [7:0] v;
    (s_read(src_a), v = src_v) ##1 s_read(cmp_a) |=> (o_cb_rdata == v);
  endproperty

  a_irq_snap_take: assert property (
    s_read(cwc_pkg::INTERRUPT_CONDITION_ADDR) |=> irq_snap == $past(i_interrupt_condition_reg))
    else $error("interrupt snapshot not taken on read");

  a_txs_snap_take: assert property (
    s_read(cwc_pkg::TRANSMIT_STATE_ADDR) |=> txs_snap == $past(i_transmit_state_reg))
    else $error("transmit snapshot not taken on read");

  a_rxa_snap_take: assert property (
    s_read(cwc_pkg::RX_CONDITION_A_ADDR) |=> rxa_snap == $past(i_rx_condition_a_reg))
    else $error("receive A snapshot not taken on read");

  a_irq_moved_kept: assert property (
    s_write(cwc_pkg::INTERRUPT_CONDITION_ADDR) |=> o_irq_wr_en
    && (((o_irq_wr_data ^ $past(i_interrupt_condition_reg))
    & $past(i_interrupt_condition_reg ^ irq_snap) & ~cwc_pkg::WRITE_INHIBIT_MASK) == 8'h00))
    else $error("moved interrupt bit was overwritten");

  a_inhibit_raised: assert property (
    (s_write(cwc_pkg::TRANSMIT_STATE_ADDR) ##0 (i_transmit_state_reg != txs_snap))
    |=> o_write_inhibit_set)
    else $error("inhibit not raised on mismatched transmit write");

  a_rxa_inhibit_raised: assert property (
    (s_write(cwc_pkg::RX_CONDITION_A_ADDR) ##0 (i_rx_condition_a_reg != rxa_snap))
    |=> o_write_inhibit_set)
    else $error("inhibit not raised on mismatched receive A write");

  a_irq_inhibit_bit: assert property (
    (s_write(cwc_pkg::INTERRUPT_CONDITION_ADDR) ##0 (i_interrupt_condition_reg != irq_snap))
    |=> o_irq_wr_data[cwc_pkg::WRITE_INHIBIT_FLAG_BIT] && o_write_inhibit_set)
    else $error("inhibit flag lost in interrupt write");

  a_txs_moved_kept: assert property (
    s_write(cwc_pkg::TRANSMIT_STATE_ADDR) |=> o_txs_wr_en
    && (((o_txs_wr_data ^ $past(i_transmit_state_reg))
    & $past(i_transmit_state_reg ^ txs_snap)) == 8'h00))
    else $error("moved transmit bit was overwritten");

  a_rxa_moved_kept: assert property (
    s_write(cwc_pkg::RX_CONDITION_A_ADDR) |=> o_rxa_wr_en
    && (((o_rxa_wr_data ^ $past(i_rx_condition_a_reg))
    & $past(i_rx_condition_a_reg ^ rxa_snap)) == 8'h00))
    else $error("moved receive A bit was overwritten");

  a_match_bits_take: assert property (
    s_write(cwc_pkg::RX_CONDITION_A_ADDR) |=> (o_rxa_wr_data & ~$past(i_rx_condition_a_reg
    ^ rxa_snap)) == ($past(i_cb_wdata) & ~$past(i_rx_condition_a_reg ^ rxa_snap)))
    else $error("unmoved bit did not take written value");

  // Judged from the live value against the snapshot, not from the inhibit decode
  a_clean_no_inhibit: assert property (
    (s_write(cwc_pkg::INTERRUPT_CONDITION_ADDR) ##0 (i_interrupt_condition_reg == irq_snap))
    |=> !o_write_inhibit_set)
    else $error("inhibit raised on a clean write");

  a_irq_readback: assert property (p_readback(cwc_pkg::INTERRUPT_CONDITION_ADDR,
    cwc_pkg::IRQ_COND_SNAPSHOT_ADDR, i_interrupt_condition_reg))
    else $error("interrupt snapshot readback wrong");

  a_txs_readback: assert property (p_readback(cwc_pkg::TRANSMIT_STATE_ADDR,
    cwc_pkg::TX_STATE_SNAPSHOT_ADDR, i_transmit_state_reg))
    else $error("transmit snapshot readback wrong");

  a_rxa_readback: assert property (p_readback(cwc_pkg::RX_CONDITION_A_ADDR,
    cwc_pkg::RX_COND_A_SNAPSHOT_ADDR, i_rx_condition_a_reg))
    else $error("receive A snapshot readback wrong");
endmodule

// ### verif/src_reg_model.sv
// Behavioural model of the three device-modified source registers.
// Assumes write, inhibit and event inputs are one-cycle pulses.
`timescale 1ns/1ps
module src_reg_model (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_wr_en,
  input wire logic [7:0] i_data [0:2],
  input wire logic [7:0] i_event [0:2],
  input wire logic i_inhibit_set,
  output logic [7:0] o_live [0:2]
);
  // Slot 0 interrupt, 1 transmit state, 2 receive A; enable bit 2 is slot 0
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_live <= '{default: 8'h00};
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        // Device events land on top of any load so a late change is never lost
        o_live[k] <= (i_wr_en[2 - k] ? i_data[k] : o_live[k]) | i_event[k]
          | ((k == 0 && i_inhibit_set) ? cwc_pkg::WRITE_INHIBIT_MASK : 8'h00);
      end
    end
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the read-before-write guard.
// Assumes the source register model above stands for the rest of the device.
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0] SRC_A [0:2] = '{cwc_pkg::INTERRUPT_CONDITION_ADDR,
    cwc_pkg::TRANSMIT_STATE_ADDR, cwc_pkg::RX_CONDITION_A_ADDR};
  localparam logic [4:0] SNAP_A [0:2] = '{cwc_pkg::IRQ_COND_SNAPSHOT_ADDR,
    cwc_pkg::TX_STATE_SNAPSHOT_ADDR, cwc_pkg::RX_COND_A_SNAPSHOT_ADDR};
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_cb_rd = 1'b0;
  logic i_cb_wr = 1'b0;
  logic [4:0] i_cb_addr = 5'h00;
  logic [7:0] i_cb_wdata = 8'h00;
  logic [7:0] ev [0:2] = '{default: 8'h00};
  logic [7:0] live [0:2];
  logic [7:0] wdat [0:2];
  logic [2:0] wen;
  logic [7:0] o_cb_rdata;
  logic o_write_inhibit_set;
  logic [7:0] d, d2, snap, mv;
  logic [7:0] exp_v [0:2] = '{default: 8'h00};
  logic inh;
  logic [2:0] en;
  int cycles = 0;
  int err_total = 0;
  int checks = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  cond_write_compare_regs cond_write_compare_regs_inst (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_cb_rd(i_cb_rd), .i_cb_wr(i_cb_wr), .i_cb_addr(i_cb_addr),
    .i_cb_wdata(i_cb_wdata), .i_interrupt_condition_reg(live[0]),
    .i_transmit_state_reg(live[1]), .i_rx_condition_a_reg(live[2]),
    .o_cb_rdata(o_cb_rdata), .o_irq_wr_en(wen[2]), .o_irq_wr_data(wdat[0]),
    .o_txs_wr_en(wen[1]), .o_txs_wr_data(wdat[1]), .o_rxa_wr_en(wen[0]),
    .o_rxa_wr_data(wdat[2]), .o_write_inhibit_set(o_write_inhibit_set));

  src_reg_model src_reg_model_inst (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_wr_en(wen), .i_data(wdat), .i_event(ev), .i_inhibit_set(o_write_inhibit_set),
    .o_live(live));

  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask

  // Entered just after a falling edge; strobe held across one rising edge, then one idle edge
  task automatic cb_read(input logic [4:0] a, output logic [7:0] rd);
    i_cb_rd = 1'b1;
    i_cb_addr = a;
    @(negedge i_sys_clk);
    i_cb_rd = 1'b0;
    rd = o_cb_rdata;
    @(negedge i_sys_clk);
  endtask

  // Two reads on consecutive edges: the strobe stays up, only the address moves
  task automatic cb_read_pair(input logic [4:0] a, input logic [4:0] b,
                              output logic [7:0] ra, output logic [7:0] rb);
    i_cb_rd = 1'b1;
    i_cb_addr = a;
    @(negedge i_sys_clk);
    ra = o_cb_rdata;
    i_cb_addr = b;
    @(negedge i_sys_clk);
    i_cb_rd = 1'b0;
    rb = o_cb_rdata;
    @(negedge i_sys_clk);
  endtask

  // Samples the one-cycle pulses, then lets the source model load
  task automatic cb_write(input logic [4:0] a, input logic [7:0] w, output logic ih,
                          output logic [2:0] we);
    i_cb_wr = 1'b1;
    i_cb_addr = a;
    i_cb_wdata = w;
    @(negedge i_sys_clk);
    i_cb_wr = 1'b0;
    ih = o_write_inhibit_set;
    we = wen;
    @(negedge i_sys_clk);
  endtask

  task automatic pulse_ev(input int i, input logic [7:0] v);
    ev[i] = v;
    @(negedge i_sys_clk);
    ev[i] = 8'h00;
  endtask

  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (5) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    @(negedge i_sys_clk);
    for (int k = 0; k < 3; k++)
    begin
      cb_read(SNAP_A[k], d);
      check("snapshot reset", d, cwc_pkg::SNAP_RESET);
    end
    for (int i = 0; i < 3; i++)
    begin
      pulse_ev(i, 8'h21);
      exp_v[i] = exp_v[i] | 8'h21;
      cb_read_pair(SRC_A[i], SNAP_A[i], d, d2);
      check("source read", d, exp_v[i]);
      snap = exp_v[i];
      check("snapshot copy", d2, snap);
      // Two bits move after the read, so the host write must not touch them
      pulse_ev(i, 8'h84);
      exp_v[i] = exp_v[i] | 8'h84;
      mv = exp_v[i] ^ snap;
      exp_v[i] = (8'h52 & ~mv) | (exp_v[i] & mv);
      exp_v[0] = exp_v[0] | cwc_pkg::WRITE_INHIBIT_MASK;
      cb_write(SRC_A[i], 8'h52, inh, en);
      check("inhibit pulse", {7'h00, inh}, 8'h01);
      check("write enable", {5'h00, en}, 8'(8'h04 >> i));
      check("merged value", live[i], exp_v[i]);
      cb_read(SRC_A[i], d);
      cb_write(SRC_A[i], 8'h3c, inh, en);
      exp_v[i] = 8'h3c;
      check("clean inhibit", {7'h00, inh}, 8'h00);
      check("clean value", live[i], exp_v[i]);
    end
    cb_write(cwc_pkg::IRQ_COND_SNAPSHOT_ADDR, 8'h77, inh, en);
    check("snapshot write enable", {5'h00, en}, 8'h00);
    cb_read(cwc_pkg::IRQ_COND_SNAPSHOT_ADDR, d);
    check("snapshot written", d, 8'h77);
    // Snapshot 77 against live 3c: moved bits 4b are kept, inhibit wins on bit 3
    cb_write(cwc_pkg::INTERRUPT_CONDITION_ADDR, 8'h00, inh, en);
    check("stale inhibit", {7'h00, inh}, 8'h01);
    check("stale merge", live[0], 8'h08);
    cb_read(5'h1d, d);
    check("unmapped read", d, cwc_pkg::READ_NONE);
    cb_write(5'h1d, 8'hff, inh, en);
    check("unmapped write", {4'h0, inh, en}, 8'h00);
    complete_run();
  end
endmodule
